// file: rtl/cbk_params.svh
// Constants of the checkback command unit
`ifndef CBK_PARAMS_SVH
`define CBK_PARAMS_SVH
`define EVT_DEPTH 8'hFA
`define LOCAL_BURST 8'h0A
`define FAR_BURST 8'h01
`define FIRST_EVENT 8'h01
`define MAX_ADDR 4'hA
`define MASTER_ADDR 4'h0
`define LOC_SLOT 4
`define SESS_MIN 15
`define SESS_SECS (`SESS_MIN * 60)
`define CLK_HZ 100000000
`define TICK_S 1
`define SEC_CYCLES (`CLK_HZ * `TICK_S)
`define LINK_BPS 60
`define ECHO_MASK 8'h2A
`endif

// file: rtl/cbk_pkg.sv
// Types shared by the checkback command unit
package cbk_pkg;
    typedef enum logic [3:0] {OP_GET_SET, OP_GET_EVE, OP_GET_STA, OP_GET_COU, OP_GET_ALL,
        OP_CLR_A, OP_CLR_E, OP_CLR_C, OP_DO_LOOP, OP_DO_CHEC, OP_LOGON, OP_LOGOFF,
        OP_HELP, OP_BAD} op_e;
    typedef enum logic [3:0] {RK_OK, RK_REJECT, RK_EVENT, RK_SETTINGS, RK_STATUS,
        RK_COUNTS, RK_HELP, RK_FWD, RK_LOGON_OK} rsp_kind_e;
    typedef struct packed {
        op_e op;
        logic has_arg;
        logic has_rng;
        logic [7:0] lo;
        logic [7:0] hi;
        logic redir;
        logic [3:0] dest;
        logic [15:0] pwd;
        logic from_link;
        logic [3:0] src;
    } cmd_s;
    typedef struct packed {
        logic [3:0] addr;
        logic prim_coded;
        logic fallback;
        logic alarm_sealed;
        logic major_close;
        logic minor_close;
        logic [3:0][4:0] hours;
        logic [6:0] period;
        logic [5:0] loop_s;
        logic [3:0] last;
        logic [15:0] pwd;
    } settings_s;
    typedef struct packed {
        logic [15:0] major;
        logic [15:0] minor;
        logic [15:0] comm_err;
        logic [15:0] retry;
        logic [15:0] tests;
        logic [15:0] passes;
        logic [31:0] elapsed;
    } count_s;
    typedef struct packed {
        logic major;
        logic minor;
        logic comm_err;
        logic retry;
        logic test;
        logic pass;
    } cnt_ev_s;
    typedef struct packed {
        logic valid;
        logic to_link;
        logic [3:0] dest;
        rsp_kind_e kind;
        logic [7:0] idx;
        cmd_s cmd;
        logic [127:0] data;
    } rsp_s;
    typedef struct packed {
        logic valid;
        logic [3:0] src;
        rsp_kind_e kind;
        logic [127:0] data;
    } rply_s;
endpackage

// file: rtl/checkback_command_unit.sv
// Command interpreter of a carrier checkback module
`timescale 1ns/100ps
`include "cbk_params.svh"
module checkback_command_unit import cbk_pkg::*; #(
    parameter int SEC_CYCLES = `SEC_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic cmd_valid,
    input cmd_s cmd_in,
    output logic cmd_ready,
    output rsp_s rsp,
    input wire logic rsp_ready,
    input rply_s rply,
    input wire logic cfg_wr,
    input settings_s cfg_in,
    output settings_s cfg,
    input wire logic ev_valid,
    input wire logic [15:0] ev_code,
    input cnt_ev_s cnt_ev,
    input wire logic echo_in_valid,
    input wire logic [7:0] echo_in_char,
    input wire logic pw_field,
    output logic echo_valid,
    output logic [7:0] echo_char,
    output logic major_relay,
    output logic minor_relay,
    output logic carrier_key,
    output logic cb_req,
    output logic [3:0] cb_addr,
    input wire logic cb_done,
    output logic local_logged_on,
    output logic is_master
);
    typedef enum logic [1:0] {ST_IDLE, ST_EVENTS, ST_SCAN, ST_WAIT} state_e;
    typedef struct packed {
        state_e state;
        settings_s cfg;
        count_s cnt;
        logic [`EVT_DEPTH-1:0][15:0] mem;
        logic [7:0] head;
        logic [7:0] num;
        logic [7:0] disp_loc;
        logic [7:0] disp_far;
        logic [7:0] cur;
        logic [7:0] last_idx;
        logic next_mode;
        logic far_req;
        logic sess_loc;
        logic [10:0] sess_far;
        logic [11:0][9:0] tmr;
        logic getall_pend;
        logic [3:0] getall_src;
        logic key;
        logic [5:0] key_s;
        logic [3:0] cb_addr;
        logic cb_req;
        logic major;
        logic minor;
        logic cmd_ready;
        rsp_s rsp;
        logic echo_valid;
        logic [7:0] echo_char;
        logic master;
    } st_s;

    st_s st_r, st_nxt;
    logic tick;

    sec_tick #(.CYCLES(SEC_CYCLES)) u_tick (
        .clock(clock),
        .resetn(resetn),
        .tick(tick)
    );

    function automatic logic [7:0] wrap(input logic [8:0] v);
        logic [8:0] d;
        d = v - {1'b0, `EVT_DEPTH};
        return (v >= {1'b0, `EVT_DEPTH}) ? d[7:0] : v[7:0];
    endfunction

    wire take = cmd_valid && st_r.cmd_ready;

    always_comb begin
        logic auth;
        logic fwd;
        logic [8:0] pos;
        logic [7:0] burst;
        auth = 1'b0;
        fwd = 1'b0;
        pos = 9'h0;
        burst = `LOCAL_BURST;
        st_nxt = st_r;
        st_nxt.cb_req = 1'b0;
        st_nxt.echo_valid = 1'b0;
        if (st_r.rsp.valid && rsp_ready) begin
            st_nxt.rsp.valid = 1'b0;
        end
        if (echo_in_valid) begin
            st_nxt.echo_valid = 1'b1;
            st_nxt.echo_char = pw_field ? `ECHO_MASK : echo_in_char;
        end
        if (cfg_wr && cfg_in.addr <= `MAX_ADDR && cfg_in.last <= `MAX_ADDR) begin
            st_nxt.cfg = cfg_in;
        end
        if (tick) begin
            st_nxt.cnt.elapsed = st_r.cnt.elapsed + 32'h1;
            if (st_r.key) begin
                st_nxt.key_s = st_r.key_s - 6'h1;
                st_nxt.key = (st_r.key_s > 6'h1);
            end
            for (int i = 0; i < 12; i++) begin
                if ((i == 11) ? st_r.sess_loc : st_r.sess_far[i]) begin
                    st_nxt.tmr[i] = st_r.tmr[i] + 10'h1;
                    if (st_r.tmr[i] == 10'(`SESS_SECS - 1)) begin
                        if (i == 11) begin
                            st_nxt.sess_loc = 1'b0;
                            st_nxt.sess_far = 11'h0;
                        end else begin
                            st_nxt.sess_far[i] = 1'b0;
                        end
                    end
                end
            end
        end
        if (rply.valid && rply.src <= `MAX_ADDR) begin
            if (rply.kind == RK_LOGON_OK) begin
                st_nxt.sess_far[rply.src] = 1'b1;
                st_nxt.tmr[rply.src] = 10'h0;
            end
            if (rply.kind == RK_SETTINGS && st_r.getall_pend && rply.src == st_r.getall_src) begin
                st_nxt.getall_pend = 1'b0;
                st_nxt.cfg = rply.data[$bits(settings_s)-1:0];
                st_nxt.cfg.addr = st_r.cfg.addr;
                st_nxt.cfg.pwd = st_r.cfg.pwd;
            end
        end
        unique case (st_r.state)
            ST_IDLE: begin
                if (take) begin
                    st_nxt.rsp.valid = 1'b1;
                    st_nxt.rsp.kind = RK_OK;
                    st_nxt.rsp.idx = 8'h0;
                    st_nxt.rsp.data = 128'h0;
                    st_nxt.rsp.to_link = cmd_in.from_link;
                    st_nxt.rsp.dest = cmd_in.src;
                    st_nxt.rsp.cmd = cmd_in;
                    fwd = !cmd_in.from_link && cmd_in.redir && cmd_in.dest != st_r.cfg.addr;
                    if (!cmd_in.from_link) begin
                        st_nxt.tmr[11] = 10'h0;
                        auth = st_r.sess_loc;
                    end else begin
                        auth = cmd_in.src <= `MAX_ADDR && st_r.sess_far[cmd_in.src];
                        if (cmd_in.op != OP_GET_EVE) begin
                            st_nxt.disp_far = `FIRST_EVENT;
                        end
                    end
                    if (cmd_in.op == OP_BAD || (cmd_in.from_link && cmd_in.src > `MAX_ADDR)) begin
                        st_nxt.rsp.kind = RK_REJECT;
                    end else if (fwd) begin
                        if (cmd_in.dest > `MAX_ADDR) begin
                            st_nxt.rsp.kind = RK_REJECT;
                        end else if (!st_r.sess_loc || (cmd_in.op != OP_LOGON
                                && !st_r.sess_far[cmd_in.dest])) begin
                            st_nxt.rsp.kind = RK_REJECT;
                        end else begin
                            st_nxt.rsp.kind = RK_FWD;
                            st_nxt.rsp.to_link = 1'b1;
                            st_nxt.rsp.dest = cmd_in.dest;
                            st_nxt.tmr[cmd_in.dest] = 10'h0;
                            if (cmd_in.op == OP_LOGOFF) begin
                                st_nxt.sess_far[cmd_in.dest] = 1'b0;
                            end
                            if (cmd_in.op == OP_GET_ALL) begin
                                st_nxt.getall_pend = 1'b1;
                                st_nxt.getall_src = cmd_in.dest;
                            end
                        end
                    end else if (cmd_in.op == OP_LOGON) begin
                        if (cmd_in.pwd != st_r.cfg.pwd) begin
                            st_nxt.rsp.kind = RK_REJECT;
                        end else if (cmd_in.from_link) begin
                            st_nxt.sess_far[cmd_in.src] = 1'b1;
                            st_nxt.tmr[cmd_in.src] = 10'h0;
                            st_nxt.rsp.kind = RK_LOGON_OK;
                        end else begin
                            st_nxt.sess_loc = 1'b1;
                        end
                    end else if (cmd_in.op == OP_LOGOFF) begin
                        if (cmd_in.from_link) begin
                            st_nxt.sess_far[cmd_in.src] = 1'b0;
                        end else begin
                            st_nxt.sess_loc = 1'b0;
                            st_nxt.sess_far = 11'h0;
                        end
                    end else if (cmd_in.op == OP_HELP) begin
                        st_nxt.rsp.kind = RK_HELP;
                        st_nxt.rsp.idx = cmd_in.lo;
                    end else if (!auth) begin
                        st_nxt.rsp.kind = RK_REJECT;
                    end else begin
                        if (cmd_in.from_link) begin
                            st_nxt.tmr[cmd_in.src] = 10'h0;
                        end
                        unique case (cmd_in.op)
                            OP_GET_SET, OP_GET_ALL: begin
                                if (!cmd_in.from_link && cmd_in.op == OP_GET_ALL) begin
                                    st_nxt.rsp.kind = RK_REJECT;
                                end else begin
                                    st_nxt.rsp.kind = RK_SETTINGS;
                                    st_nxt.rsp.data = 128'(st_r.cfg);
                                end
                            end
                            OP_GET_STA: begin
                                st_nxt.rsp.kind = RK_STATUS;
                                st_nxt.rsp.data = {123'h0, st_r.sess_loc,
                                    st_r.state == ST_SCAN || st_r.state == ST_WAIT,
                                    st_r.key, st_r.minor, st_r.major};
                            end
                            OP_GET_COU: begin
                                st_nxt.rsp.kind = RK_COUNTS;
                                st_nxt.rsp.data = st_r.cnt;
                            end
                            OP_CLR_A: begin
                                st_nxt.major = 1'b0;
                                st_nxt.minor = 1'b0;
                            end
                            OP_CLR_E: begin
                                st_nxt.num = 8'h0;
                                st_nxt.head = 8'h0;
                                st_nxt.disp_loc = `FIRST_EVENT;
                                st_nxt.disp_far = `FIRST_EVENT;
                            end
                            OP_CLR_C: begin
                                st_nxt.cnt = '0;
                            end
                            OP_DO_LOOP: begin
                                st_nxt.key = st_r.cfg.loop_s != 6'h0;
                                st_nxt.key_s = st_r.cfg.loop_s;
                            end
                            OP_DO_CHEC: begin
                                st_nxt.rsp.valid = 1'b0;
                                st_nxt.cb_addr = `MASTER_ADDR;
                                st_nxt.state = ST_SCAN;
                            end
                            OP_GET_EVE: begin
                                burst = cmd_in.from_link ? `FAR_BURST : `LOCAL_BURST;
                                st_nxt.rsp.valid = 1'b0;
                                st_nxt.far_req = cmd_in.from_link;
                                st_nxt.next_mode = !cmd_in.has_arg;
                                if (!cmd_in.has_arg) begin
                                    st_nxt.cur = cmd_in.from_link ? st_r.disp_far
                                        : st_r.disp_loc;
                                    st_nxt.last_idx = st_nxt.cur + burst - 8'h1;
                                end else begin
                                    st_nxt.cur = cmd_in.lo;
                                    st_nxt.last_idx = cmd_in.has_rng ? cmd_in.hi : cmd_in.lo;
                                end
                                if (cmd_in.has_arg && (cmd_in.lo == 8'h0 || cmd_in.lo
                                        > `EVT_DEPTH || (cmd_in.has_rng
                                        && cmd_in.hi < cmd_in.lo))) begin
                                    st_nxt.rsp.valid = 1'b1;
                                    st_nxt.rsp.kind = RK_REJECT;
                                end else begin
                                    st_nxt.state = ST_EVENTS;
                                end
                            end
                            default: begin
                                st_nxt.rsp.kind = RK_REJECT;
                            end
                        endcase
                    end
                end
            end
            ST_EVENTS: begin
                if (!st_nxt.rsp.valid) begin
                    st_nxt.rsp.valid = 1'b1;
                    if (st_r.cur <= st_r.last_idx && st_r.cur <= st_r.num) begin
                        pos = {1'b0, st_r.head} + {1'b0, st_r.cur} - 9'h1;
                        st_nxt.rsp.kind = RK_EVENT;
                        st_nxt.rsp.idx = st_r.cur;
                        st_nxt.rsp.data = {112'h0, st_r.mem[wrap(pos)]};
                        st_nxt.cur = st_r.cur + 8'h1;
                    end else begin
                        st_nxt.rsp.kind = RK_OK;
                        st_nxt.rsp.idx = 8'h0;
                        st_nxt.state = ST_IDLE;
                        if (st_r.next_mode && st_r.far_req) begin
                            st_nxt.disp_far = st_r.cur;
                        end else if (st_r.next_mode) begin
                            st_nxt.disp_loc = st_r.cur;
                        end
                    end
                end
            end
            ST_SCAN: begin
                if (st_r.cb_addr > st_r.cfg.last) begin
                    st_nxt.state = ST_IDLE;
                    st_nxt.rsp.valid = 1'b1;
                    st_nxt.rsp.kind = RK_OK;
                end else if (st_r.cb_addr == st_r.cfg.addr) begin
                    st_nxt.cb_addr = st_r.cb_addr + 4'h1;
                end else begin
                    st_nxt.cb_req = 1'b1;
                    st_nxt.state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (cb_done) begin
                    st_nxt.cb_addr = st_r.cb_addr + 4'h1;
                    st_nxt.state = ST_SCAN;
                end
            end
        endcase
        // Hardware events land after clears so a clear in the same cycle does not drop them; a full store overwrites its oldest entry
        if (ev_valid) begin
            if (st_nxt.num < `EVT_DEPTH) begin
                st_nxt.mem[wrap({1'b0, st_nxt.head} + {1'b0, st_nxt.num})] = ev_code;
                st_nxt.num = st_nxt.num + 8'h1;
            end else begin
                st_nxt.mem[st_nxt.head] = ev_code;
                st_nxt.head = wrap({1'b0, st_nxt.head} + 9'h1);
            end
        end
        if (cnt_ev.major) begin
            st_nxt.major = 1'b1;
            st_nxt.cnt.major = st_nxt.cnt.major + 16'h1;
        end
        if (cnt_ev.minor) begin
            st_nxt.minor = 1'b1;
            st_nxt.cnt.minor = st_nxt.cnt.minor + 16'h1;
        end
        st_nxt.cnt.comm_err = st_nxt.cnt.comm_err + {15'h0, cnt_ev.comm_err};
        st_nxt.cnt.retry = st_nxt.cnt.retry + {15'h0, cnt_ev.retry};
        st_nxt.cnt.tests = st_nxt.cnt.tests + {15'h0, cnt_ev.test};
        st_nxt.cnt.passes = st_nxt.cnt.passes + {15'h0, cnt_ev.pass};
        st_nxt.master = st_nxt.cfg.addr == `MASTER_ADDR;
        st_nxt.cmd_ready = st_nxt.state == ST_IDLE && !st_nxt.rsp.valid;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
            st_r.disp_loc <= `FIRST_EVENT;
            st_r.disp_far <= `FIRST_EVENT;
            st_r.master <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cmd_ready = st_r.cmd_ready;
    assign rsp = st_r.rsp;
    assign cfg = st_r.cfg;
    assign echo_valid = st_r.echo_valid;
    assign echo_char = st_r.echo_char;
    assign major_relay = st_r.major;
    assign minor_relay = st_r.minor;
    assign carrier_key = st_r.key;
    assign cb_req = st_r.cb_req;
    assign cb_addr = st_r.cb_addr;
    assign local_logged_on = st_r.sess_loc;
    assign is_master = st_r.master;

    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    a_echo_mask: assert property (echo_in_valid && pw_field |=> echo_valid
        && echo_char == `ECHO_MASK) else $error("password echo not masked");
    a_bad_reject: assert property (take && cmd_in.op == OP_BAD |=> rsp.valid
        && rsp.kind == RK_REJECT && cmd_ready == 1'b0) else $error("bad command accepted");
    a_fwd_path: assert property (take && !cmd_in.from_link && cmd_in.redir
        && local_logged_on && cmd_in.dest != cfg.addr && cmd_in.dest <= `MAX_ADDR
        && cmd_in.op == OP_LOGON |=> rsp.kind == RK_FWD && rsp.to_link)
        else $error("redirect not forwarded");
    a_logoff_all: assert property (take && !cmd_in.from_link && !cmd_in.redir
        && cmd_in.op == OP_LOGOFF |=> !local_logged_on && st_r.sess_far == 11'h0)
        else $error("logoff left sessions");
    a_noauth_set: assert property (take && !cmd_in.from_link && !cmd_in.redir
        && !local_logged_on && cmd_in.op == OP_GET_SET |=> rsp.kind == RK_REJECT)
        else $error("settings shown without logon");
    a_evt_bound: assert property (st_r.num <= `EVT_DEPTH) else $error("event store overflow");
    a_key_end: assert property (carrier_key && tick && st_r.key_s == 6'h1
        && !(take && cmd_in.op == OP_DO_LOOP) |=> !carrier_key)
        else $error("loopback overran");
    a_sess_expire: assert property (tick && local_logged_on && !take
        && st_r.tmr[11] == 10'(`SESS_SECS - 1) |=> !local_logged_on)
        else $error("session not timed out");
    a_clr_alarm: assert property (take && local_logged_on && !cmd_in.redir
        && !cmd_in.from_link && cmd_in.op == OP_CLR_A && !cnt_ev.major |=> !major_relay)
        else $error("alarm relay not released");
    a_master_role: assert property (is_master == (cfg.addr == `MASTER_ADDR))
        else $error("master role lost");
endmodule // checkback_command_unit

// file: rtl/sec_tick.sv
// One-second enable pulse divider
`timescale 1ns/100ps
module sec_tick #(
    parameter int CYCLES = 100000000
) (
    input wire logic clock,
    input wire logic resetn,
    output logic tick
);
    logic [31:0] cnt_r;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 32'h0;
            tick <= 1'b0;
        end else begin
            tick <= (cnt_r == 32'(CYCLES - 1));
            cnt_r <= (cnt_r == 32'(CYCLES - 1)) ? 32'h0 : cnt_r + 32'h1;
        end
    end
endmodule // sec_tick

// file: test/cbk_far_model.sv
// Far side: terminal accepting answers and distant modules answering tests
`timescale 1ns/100ps
module cbk_far_model (
    input wire logic clock,
    input wire logic resetn,
    input wire logic rsp_valid,
    output logic rsp_ready,
    input wire logic cb_req,
    output logic cb_done
);
    logic [1:0] wait_r;
    logic [1:0] cb_r;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wait_r <= 2'h0;
            cb_r <= 2'h0;
            rsp_ready <= 1'b0;
            cb_done <= 1'b0;
        end else begin
            // Slow consumer: accepts only after the answer has stood a while
            wait_r <= (rsp_valid && !rsp_ready) ? wait_r + 2'h1 : 2'h0;
            rsp_ready <= rsp_valid && !rsp_ready && wait_r == 2'h2;
            cb_r <= {cb_r[0], cb_req};
            cb_done <= cb_r[1];
        end
    end
endmodule // cbk_far_model

// file: test/checkback_command_unit_tb_top.sv
// Self-checking bench of the checkback command unit
`timescale 1ns/100ps
module checkback_command_unit_tb_top import cbk_pkg::*;;
    logic clock = 0, resetn = 0, cmd_valid = 0, cmd_ready, rsp_ready, cfg_wr = 0;
    logic echo_in_valid = 0, pw_field = 0, echo_valid, major_relay, minor_relay;
    logic carrier_key, cb_req, cb_done, local_logged_on, is_master;
    logic [7:0] echo_in_char = 8'h00, echo_char;
    logic [3:0] cb_addr;
    cmd_s cmd_in = '0;
    rsp_s rsp;
    settings_s cfg_in = '0, cfg;
    rsp_kind_e kind;
    rsp_s got;
    cnt_ev_s cnt_ev = '0;
    logic ev_valid = 0;
    logic [15:0] ev_code = 16'h0000;
    int failures = 0, check_count = 0, cycles = 0, cb_seen = 0;
    checkback_command_unit #(.SEC_CYCLES(10)) u_checkback_command_unit (.clock(clock),
        .resetn(resetn), .cmd_valid(cmd_valid), .cmd_in(cmd_in), .cmd_ready(cmd_ready),
        .rsp(rsp), .rsp_ready(rsp_ready), .rply('0), .cfg_wr(cfg_wr), .cfg_in(cfg_in),
        .cfg(cfg), .ev_valid(ev_valid), .ev_code(ev_code), .cnt_ev(cnt_ev),
        .echo_in_valid(echo_in_valid), .echo_in_char(echo_in_char), .pw_field(pw_field),
        .echo_valid(echo_valid), .echo_char(echo_char), .major_relay(major_relay),
        .minor_relay(minor_relay), .carrier_key(carrier_key), .cb_req(cb_req),
        .cb_addr(cb_addr), .cb_done(cb_done), .local_logged_on(local_logged_on),
        .is_master(is_master));
    cbk_far_model u_cbk_far_model (.clock(clock), .resetn(resetn), .rsp_valid(rsp.valid),
        .rsp_ready(rsp_ready), .cb_req(cb_req), .cb_done(cb_done));
    initial forever #5 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cb_req === 1'b1) cb_seen <= cb_seen + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            conclude();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        check_count = check_count + 1;
        if (seen !== want) begin
            failures = failures + 1;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic conclude();
        if (failures == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic send_cmd(input cmd_s c);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_in <= c;
        do @(posedge clock); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        do @(posedge clock); while (!(rsp.valid === 1'b1 && rsp_ready === 1'b1));
        kind = rsp.kind;
        got = rsp;
    endtask
    task automatic send(input op_e op, input logic [15:0] pwd);
        send_cmd('{op: op, pwd: pwd, default: '0});
    endtask
    task automatic load_cfg(input logic [3:0] addr);
        @(posedge clock);
        cfg_wr <= 1'b1;
        cfg_in <= '{addr: addr, loop_s: 6'h04, last: 4'h2, pwd: 16'h1234, default: '0};
        @(posedge clock);
        cfg_wr <= 1'b0;
        @(posedge clock);
        @(posedge clock);
    endtask
    task automatic test_logon();
        send(OP_GET_STA, 16'h0000);
        check(kind == RK_REJECT, 1);
        send(OP_LOGON, 16'h0000);
        check(kind == RK_REJECT, 1);
        send(OP_BAD, 16'h0000);
        check(kind == RK_REJECT, 1);
        send(OP_LOGON, 16'h1234);
        check(local_logged_on, 1);
        send(OP_GET_STA, 16'h0000);
        check(kind, RK_STATUS);
        check(got.data[15:0], 16'h0010);
    endtask
    task automatic test_redir();
        send_cmd('{op: OP_LOGON, redir: 1'b1, dest: 4'h2, pwd: 16'h1234, default: '0});
        check(got.kind, RK_FWD);
        check({got.to_link, got.dest}, 16'h0012);
        check(got.cmd.pwd, 16'h1234);
        send_cmd('{op: OP_GET_STA, redir: 1'b1, dest: 4'h2, default: '0});
        check(got.kind, RK_REJECT);
    endtask
    task automatic test_alarm();
        @(posedge clock);
        cnt_ev <= '{major: 1'b1, minor: 1'b1, default: '0};
        @(posedge clock);
        cnt_ev <= '0;
        send(OP_GET_COU, 16'h0000);
        check(got.data[127:112], 16'h0001);
        check({major_relay, minor_relay}, 16'h0003);
        send(OP_CLR_A, 16'h0000);
        check({major_relay, minor_relay}, 16'h0000);
        send(OP_CLR_C, 16'h0000);
        send(OP_GET_COU, 16'h0000);
        check(got.data[127:112], 16'h0000);
    endtask
    task automatic test_events();
        @(posedge clock);
        ev_valid <= 1'b1;
        ev_code <= 16'hBEEF;
        @(posedge clock);
        ev_valid <= 1'b0;
        send_cmd('{op: OP_GET_EVE, has_arg: 1'b1, lo: 8'h01, default: '0});
        check(got.kind, RK_EVENT);
        check(got.data[15:0], 16'hBEEF);
        send(OP_GET_EVE, 16'h0000);
        check(got.idx, 8'h01);
        send(OP_GET_EVE, 16'h0000);
        check(got.kind, RK_OK);
        send_cmd('{op: OP_GET_EVE, has_arg: 1'b1, lo: 8'h00, default: '0});
        check(got.kind, RK_REJECT);
        send(OP_CLR_E, 16'h0000);
        send_cmd('{op: OP_GET_EVE, has_arg: 1'b1, lo: 8'h01, default: '0});
        check(got.kind, RK_OK);
    endtask
    task automatic test_loop();
        send(OP_DO_LOOP, 16'h0000);
        repeat (18) @(posedge clock);
        check(carrier_key, 1);
        repeat (35) @(posedge clock);
        check(carrier_key, 0);
    endtask
    task automatic test_echo(input logic pw, input logic [15:0] want);
        @(posedge clock);
        {echo_in_valid, pw_field, echo_in_char} <= {1'b1, pw, 8'h61};
        @(posedge clock);
        echo_in_valid <= 1'b0;
        @(posedge clock);
        check({echo_valid, echo_char}, want);
    endtask
    initial begin
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        repeat (2) @(posedge clock);
        check(is_master, 1);
        load_cfg(4'h1);
        check(is_master, 0);
        load_cfg(4'hB);
        check(cfg.addr, 1);
        test_logon();
        test_redir();
        test_alarm();
        test_events();
        send(OP_DO_CHEC, 16'h0000);
        check(kind, RK_OK);
        check(cb_seen, 2);
        test_loop();
        test_echo(1'b1, 16'h012A);
        test_echo(1'b0, 16'h0161);
        send(OP_LOGOFF, 16'h0000);
        check(local_logged_on, 0);
        conclude();
    end
endmodule // checkback_command_unit_tb_top
